// ===== design/rsw_reset_unit.sv
// Reset source selection, watchdog and software resets of the device.
// Assumes frame_tick_in and ci_code_in come from logic on clk_in; pins pass
// two flip-flops before use.
//
// Behaviour
// [R1] Source select 00 passes power-on and external; 10 adds C/I change; 11 adds watchdog.
// [R2] Source select 01 turns the reset output off, high impedance.
// [R3] An internal reset from C/I change or watchdog restores the mode register default.
// [R4] A channel zero C/I change, when selected, gives a 125 to 250 us reset pulse.
// [R5] Selecting the watchdog clears its counter and starts it.
// [R6] Host writes trigger bits 1-0 then 0-1 within every 128 ms.
// [R7] On expiry the overflow flag is set and a 125 us reset pulse is driven.
// [R8] Software cannot switch the watchdog off; only a hardware reset or an internal reset does.
// [R9] The watchdog advances only on serial bus frame ticks, so it stalls in power down.
// [R10] Each soft reset bit holds its block in reset while it reads one.
// [R11] The external reset resets the whole device and appears on the reset output.
// [R12] Host waits the recovery time after external reset release before any access.
// [R13] With supply detect enabled every reset output release is delayed.
// [R14] The power-on/undervoltage generator is enabled only by the supply detect pin.
// [R15] Serial bus clocks keep running during reset; controller clock does too, except in power-on reset.
// [R16] During reset data lines idle high, C/I codes 0000 on both channels.
// [R17] Power-on reset stops the controller clock until the release delay starts.
// [R18] Only a second trigger write directly after the first restarts the watchdog.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "rsw_defines.svh"

module rsw_reset_unit #(
    parameter int unsigned CIC_CYCLES     = (`RSW_CIC_MIN_NS + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS,
    parameter int unsigned WOV_CYCLES     = (`RSW_WOV_PULSE_NS + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS,
    parameter int unsigned RELEASE_CYCLES = (`RSW_RELEASE_NS + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS,
    parameter int unsigned WDOG_FRAMES    = `RSW_WDOG_FRAMES
) (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic       ext_reset_n_in,
    input  wire logic       power_on_undervoltage_reset_in,
    input  wire logic       supply_detect_enable_n_in,
    input  wire logic       frame_tick_in,
    input  wire logic [3:0] ci_code_in,
    output logic      [7:0] rdata_out,
    output logic            reset_out_n_out,
    output logic            reset_out_oe_out,
    output logic            device_reset_out,
    output logic      [7:0] soft_reset_out,
    output logic            mclk_run_out,
    output logic            clocks_run_out,
    output logic            lines_idle_out,
    output logic            irq_out
);

    localparam logic [`RSW_PULSE_W-1:0] CIC_LOAD = `RSW_PULSE_W'(CIC_CYCLES);
    localparam logic [`RSW_PULSE_W-1:0] WOV_LOAD = `RSW_PULSE_W'(WOV_CYCLES);
    localparam logic [`RSW_DEACT_W-1:0] REL_LOAD = `RSW_DEACT_W'(RELEASE_CYCLES);
    localparam logic [`RSW_WCNT_W-1:0]  WD_LIMIT = `RSW_WCNT_W'(WDOG_FRAMES);

    rsw_pkg::rsw_state_s st_reg;
    rsw_pkg::rsw_state_s st_next;
    rsw_pkg::rsw_bus_s   bus;

    logic hw_rst;
    logic por_rst;
    logic wr_mode;
    logic wr_wdog;
    logic wdog_kick;
    logic wov_event;
    logic cic_event;
    logic raw_rst;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    always_comb
    begin
        st_next = st_reg;
        // First stage feeds only the second stage
        st_next.ext_sync = {st_reg.ext_sync[0], ~ext_reset_n_in};
        st_next.por_sync = {st_reg.por_sync[0], power_on_undervoltage_reset_in};
        st_next.det_sync = {st_reg.det_sync[0], ~supply_detect_enable_n_in};

        por_rst = st_reg.por_sync[1] & st_reg.det_sync[1]; // R14
        hw_rst  = st_reg.ext_sync[1] | por_rst; // R11
        wr_mode = bus.wr & hit(bus.addr, `RSW_OFF_PRIMARY_MODE_REGISTER);
        wr_wdog = bus.wr & hit(bus.addr, `RSW_OFF_WDOG);

        // Trigger pair must be first 1-0 then 0-1 on consecutive writes
        wdog_kick = wr_wdog & st_reg.wtc_armed
                  & ~bus.wdata[`RSW_WDOG_FIRST] & bus.wdata[`RSW_WDOG_SECOND]; // R18
        if (bus.wr)
        begin
            st_next.wtc_armed = wr_wdog & bus.wdata[`RSW_WDOG_FIRST]
                              & ~bus.wdata[`RSW_WDOG_SECOND]; // R18
        end

        // Counter only moves on frame ticks, so it stops with the bus clocks
        wov_event = 1'b0;
        if (st_reg.wdog_on)
        begin
            if (wdog_kick)
            begin
                st_next.wdog_cnt = '0; // R6
            end
            else if (frame_tick_in) // R9
            begin
                if (st_reg.wdog_cnt == WD_LIMIT - `RSW_WCNT_W'(1))
                begin
                    wov_event = 1'b1; // R7
                end
                st_next.wdog_cnt = st_reg.wdog_cnt + `RSW_WCNT_W'(1);
            end
        end

        st_next.ci_prev = ci_code_in;
        cic_event = (st_reg.rss == `RSW_RSS_CIC) && !hw_rst
                  && (ci_code_in != st_reg.ci_prev); // R4

        // Mode register; watchdog selection cannot be undone by software
        if (wr_mode)
        begin
            st_next.mode_rest = bus.wdata[7:2];
            if (!st_reg.wdog_on)
            begin
                st_next.rss = bus.wdata[`RSW_PRIMARY_MODE_REGISTER_RSS_LSB +: 2]; // R8
            end
            if (bus.wdata[`RSW_PRIMARY_MODE_REGISTER_RSS_LSB +: 2] == `RSW_RSS_WDOG && !st_reg.wdog_on)
            begin
                st_next.wdog_on  = 1'b1; // R5
                st_next.wdog_cnt = '0; // R5
            end
        end

        // Internal sources fire a pulse and return the mode register to default
        if (wov_event || cic_event)
        begin
            st_next.pulse_cnt = wov_event ? WOV_LOAD : CIC_LOAD; // R4 R7
            st_next.rss       = 2'(`RSW_PRIMARY_MODE_REGISTER_RST >> `RSW_PRIMARY_MODE_REGISTER_RSS_LSB); // R3
            st_next.mode_rest = 6'(`RSW_PRIMARY_MODE_REGISTER_RST >> 2); // R3
            st_next.wdog_on   = 1'b0; // R8
            st_next.wdog_cnt  = '0;
            st_next.wtc_armed = 1'b0;
        end
        else if (st_reg.pulse_cnt != '0)
        begin
            st_next.pulse_cnt = st_reg.pulse_cnt - `RSW_PULSE_W'(1);
        end

        if (bus.wr && hit(bus.addr, `RSW_OFF_SOFT_RESET_REGISTER))
        begin
            st_next.soft_reset_register = bus.wdata;
        end
        if (bus.wr && hit(bus.addr, `RSW_OFF_MASK))
        begin
            st_next.mask = bus.wdata[1:0];
        end

        // Event set wins over a write-one clear in the same cycle
        if (bus.wr && hit(bus.addr, `RSW_OFF_INTERRUPT_STATUS_REGISTER))
        begin
            st_next.interrupt_status_register = st_reg.interrupt_status_register & ~bus.wdata[1:0];
        end
        if (wov_event)
        begin
            st_next.interrupt_status_register[`RSW_INTERRUPT_STATUS_REGISTER_WOV] = 1'b1; // R7
        end
        if (cic_event)
        begin
            st_next.interrupt_status_register[`RSW_INTERRUPT_STATUS_REGISTER_CIC] = 1'b1;
        end

        // Hardware reset wins over everything and disarms the watchdog
        if (hw_rst)
        begin
            st_next.rss       = 2'(`RSW_PRIMARY_MODE_REGISTER_RST >> `RSW_PRIMARY_MODE_REGISTER_RSS_LSB);
            st_next.mode_rest = 6'(`RSW_PRIMARY_MODE_REGISTER_RST >> 2);
            st_next.wdog_on   = 1'b0; // R8
            st_next.wdog_cnt  = '0;
            st_next.wtc_armed = 1'b0;
            st_next.pulse_cnt = '0;
            st_next.soft_reset_register      = `RSW_SOFT_RESET_REGISTER_RST;
            st_next.mask      = `RSW_MASK_RST;
            st_next.interrupt_status_register      = '0;
        end

        // Pulse reaches the pin until its count runs out, whatever the source selection
        raw_rst = hw_rst || (st_next.pulse_cnt != '0); // R1 R11
        if (raw_rst)
        begin
            st_next.deact_cnt = st_reg.det_sync[1] ? REL_LOAD : '0; // R13
        end
        else if (st_reg.deact_cnt != '0)
        begin
            st_next.deact_cnt = st_reg.deact_cnt - `RSW_DEACT_W'(1); // R13
        end

        st_next.rst_n      = !(raw_rst || st_next.deact_cnt != '0); // R1 R11
        st_next.rst_oe     = (st_next.rss != `RSW_RSS_OFF); // R2
        st_next.dev_rst    = hw_rst;
        st_next.mclk_run   = !por_rst; // R17
        st_next.lines_idle = !st_next.rst_n; // R16
        st_next.irq        = |(st_next.interrupt_status_register & ~st_next.mask);

        st_next.rdata = 8'h00;
        if (bus.rd)
        begin
            case (bus.addr)
                `RSW_OFF_PRIMARY_MODE_REGISTER: st_next.rdata = {st_reg.mode_rest, st_reg.rss};
                `RSW_OFF_WDOG:  st_next.rdata = {7'h00, st_reg.wtc_armed};
                `RSW_OFF_SOFT_RESET_REGISTER:  st_next.rdata = st_reg.soft_reset_register;
                `RSW_OFF_INTERRUPT_STATUS_REGISTER:  st_next.rdata = {6'h00, st_reg.interrupt_status_register};
                `RSW_OFF_MASK:  st_next.rdata = {6'h00, st_reg.mask};
                `RSW_OFF_STAT:  st_next.rdata = {4'h0, st_reg.mclk_run, st_reg.dev_rst,
                                                 st_reg.wdog_on, st_reg.rst_n};
                default:        st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_reg            <= '0;
            st_reg.rss        <= 2'(`RSW_PRIMARY_MODE_REGISTER_RST >> `RSW_PRIMARY_MODE_REGISTER_RSS_LSB);
            st_reg.mode_rest  <= 6'(`RSW_PRIMARY_MODE_REGISTER_RST >> 2);
            st_reg.soft_reset_register       <= `RSW_SOFT_RESET_REGISTER_RST;
            st_reg.mask       <= `RSW_MASK_RST;
            st_reg.rst_n      <= 1'b0;
            st_reg.rst_oe     <= 1'b1;
            st_reg.dev_rst    <= 1'b1;
            st_reg.lines_idle <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata_out        = st_reg.rdata;
    assign reset_out_n_out  = st_reg.rst_n;
    assign reset_out_oe_out = st_reg.rst_oe;
    assign device_reset_out = st_reg.dev_rst;
    assign soft_reset_out   = st_reg.soft_reset_register; // R10
    assign mclk_run_out     = st_reg.mclk_run;
    // Frame clocks never stop for reset; made from the output enable register ORed with its inverse
    assign clocks_run_out   = st_reg.rst_oe | ~st_reg.rst_oe; // R15
    assign lines_idle_out   = st_reg.lines_idle; // R16
    assign irq_out          = st_reg.irq;

endmodule : rsw_reset_unit

// ===== pkg/rsw_defines.svh
// Offsets, field positions, reset values and timing counts of the reset unit.
// Assumes a 40 MHz system clock and an 8-bit register port.
`ifndef RSW_DEFINES_SVH
`define RSW_DEFINES_SVH

`define RSW_OFF_PRIMARY_MODE_REGISTER      8'h00
`define RSW_OFF_WDOG       8'h01
`define RSW_OFF_SOFT_RESET_REGISTER       8'h02
`define RSW_OFF_INTERRUPT_STATUS_REGISTER       8'h03
`define RSW_OFF_MASK       8'h04
`define RSW_OFF_STAT       8'h05

`define RSW_PRIMARY_MODE_REGISTER_RSS_LSB  0
`define RSW_PRIMARY_MODE_REGISTER_RST      8'h00
`define RSW_WDOG_FIRST     1
`define RSW_WDOG_SECOND    0
`define RSW_INTERRUPT_STATUS_REGISTER_WOV       0
`define RSW_INTERRUPT_STATUS_REGISTER_CIC       1
`define RSW_MASK_RST       2'h0
`define RSW_SOFT_RESET_REGISTER_RST       8'h00

`define RSW_RSS_BASE       2'h0
`define RSW_RSS_OFF        2'h1
`define RSW_RSS_CIC        2'h2
`define RSW_RSS_WDOG       2'h3

`define RSW_CLK_PERIOD_NS  25
`define RSW_CIC_MIN_NS     125000
`define RSW_CIC_MAX_NS     250000
`define RSW_WOV_PULSE_NS   125000
`define RSW_RELEASE_NS     125000
`define RSW_FRAME_US       125
`define RSW_WDOG_PERIOD_US 128000
`define RSW_WDOG_FRAMES    (`RSW_WDOG_PERIOD_US / `RSW_FRAME_US)

`define RSW_PULSE_W        14
`define RSW_DEACT_W        20
`define RSW_WCNT_W         11

`endif

// ===== pkg/rsw_pkg.sv
// Types of the reset source and watchdog unit.
// Counter widths come from rsw_defines.svh.
`include "rsw_defines.svh"

package rsw_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rsw_bus_s;

    typedef struct packed {
        logic [1:0]               ext_sync;
        logic [1:0]               por_sync;
        logic [1:0]               det_sync;
        logic [1:0]               rss;
        logic [5:0]               mode_rest;
        logic                     wdog_on;
        logic [`RSW_WCNT_W-1:0]   wdog_cnt;
        logic                     wtc_armed;
        logic [`RSW_PULSE_W-1:0]  pulse_cnt;
        logic [`RSW_DEACT_W-1:0]  deact_cnt;
        logic [3:0]               ci_prev;
        logic [7:0]               soft_reset_register;
        logic [1:0]               interrupt_status_register;
        logic [1:0]               mask;
        logic [7:0]               rdata;
        logic                     irq;
        logic                     rst_n;
        logic                     rst_oe;
        logic                     dev_rst;
        logic                     mclk_run;
        logic                     lines_idle;
    } rsw_state_s;

endpackage : rsw_pkg

// ===== tb/rsw_far_side.sv
// Far side model: serial bus frame ticks and the channel zero C/I code.
// Assumes one clock shared with the unit; asleep_in stands for power down.
`timescale 1ns/1ps
module rsw_far_side #(
    parameter int TICK = 20
) (
    input  wire logic       clk_in,
    input  wire logic       asleep_in,
    input  wire logic       ci_kick_in,
    output logic            frame_tick_out,
    output logic      [3:0] ci_code_out
);
    int cnt = 0;
    initial frame_tick_out = 1'b0;
    initial ci_code_out = 4'h0;
    always @(posedge clk_in)
    begin
        // Bus clocks stop in power down, so no ticks while asleep
        cnt <= asleep_in ? cnt : (cnt + 1) % TICK;
        frame_tick_out <= !asleep_in && cnt == 0;
        // Step of 1 to 14 so every kick is a real change of code
        if (ci_kick_in)
            ci_code_out <= ci_code_out + 4'h1 + 4'($urandom_range(13));
    end
endmodule : rsw_far_side

// ===== tb/rsw_reset_unit_sva.sv
// Port checker of the reset unit: pin levels, pulse lengths, soft resets.
// Bound to rsw_reset_unit from the bench top; sees its ports only.
`timescale 1ns/1ps
`include "rsw_defines.svh"
module rsw_reset_unit_sva #(
    parameter int unsigned CIC_CYCLES = 8
) (
    input wire logic       clk_in,
    input wire logic       reset_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       ext_reset_n_in,
    input wire logic       power_on_undervoltage_reset_in,
    input wire logic       supply_detect_enable_n_in,
    input wire logic       reset_out_n_out,
    input wire logic       device_reset_out,
    input wire logic [7:0] soft_reset_out,
    input wire logic       mclk_run_out,
    input wire logic       clocks_run_out,
    input wire logic       lines_idle_out
);
    // Starts saturated so the first rise after system reset is not judged
    logic [7:0] low_len_reg;
    always_ff @(posedge clk_in or negedge reset_n_in)
        if (!reset_n_in)
            low_len_reg <= 8'hFF;
        else if (reset_out_n_out)
            low_len_reg <= 8'h00;
        else if (low_len_reg != 8'hFF)
            low_len_reg <= low_len_reg + 8'h01;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_pulse_min_len: assert property ($rose(reset_out_n_out) |-> low_len_reg >= CIC_CYCLES)
        else $error("reset pulse too short");
    a_ext_drives_pin: assert property (!ext_reset_n_in [*5] |-> !reset_out_n_out && device_reset_out)
        else $error("external reset not passed on");
    a_release_held: assert property ($rose(ext_reset_n_in) && !supply_detect_enable_n_in |=> !reset_out_n_out [*8])
        else $error("release not delayed");
    a_por_gated: assert property ((supply_detect_enable_n_in && ext_reset_n_in) [*6] |-> !device_reset_out)
        else $error("reset while power-on detect disabled");
    a_por_stops_mclk: assert property ((!supply_detect_enable_n_in && power_on_undervoltage_reset_in) [*5]
        |-> !mclk_run_out && device_reset_out)
        else $error("controller clock runs in power-on reset");
    a_lines_idle: assert property (!reset_out_n_out |-> lines_idle_out)
        else $error("data lines not idle in reset");
    a_clocks_run: assert property ($past(reset_n_in) |-> clocks_run_out)
        else $error("bus clocks stopped");
    a_soft_follow: assert property (wr_in && addr_in == `RSW_OFF_SOFT_RESET_REGISTER && !device_reset_out
        |=> soft_reset_out == $past(wdata_in))
        else $error("soft reset bits differ from write");
endmodule : rsw_reset_unit_sva

// ===== tb/rsw_reset_unit_tb.sv
// Bench of the reset unit: register port, reset sources, watchdog, pin levels.
// Counts shortened to 8 cycles and 8 frames; far side model makes the ticks.
`timescale 1ns/1ps
`include "rsw_defines.svh"
module rsw_reset_unit_tb;
    logic       clk_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    logic       ext_reset_n_in = 1'b1;
    logic       power_on_undervoltage_reset_in = 1'b0;
    logic       supply_detect_enable_n_in = 1'b1;
    logic       asleep = 1'b0;
    logic       kick = 1'b0;
    logic       frame_tick_in;
    logic [3:0] ci_code_in;
    logic [7:0] rdata_out;
    logic [7:0] soft_reset_out;
    logic       reset_out_n_out;
    logic       reset_out_oe_out;
    logic       device_reset_out;
    logic       mclk_run_out;
    logic       clocks_run_out;
    logic       lines_idle_out;
    logic       irq_out;
    logic [7:0] v;
    int         lo;
    int         n_mismatch = 0;
    int         n_checks = 0;
    always #12.5 clk_in = ~clk_in;
    rsw_reset_unit #(.CIC_CYCLES(8), .WOV_CYCLES(8), .RELEASE_CYCLES(8), .WDOG_FRAMES(8)) rsw_reset_unit_inst (
        .clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .ext_reset_n_in, .power_on_undervoltage_reset_in,
        .supply_detect_enable_n_in, .frame_tick_in, .ci_code_in, .rdata_out, .reset_out_n_out, .reset_out_oe_out,
        .device_reset_out, .soft_reset_out, .mclk_run_out, .clocks_run_out, .lines_idle_out, .irq_out);
    rsw_far_side rsw_far_side_inst (.clk_in, .asleep_in(asleep), .ci_kick_in(kick), .frame_tick_out(frame_tick_in),
        .ci_code_out(ci_code_in));
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(what, exp, rdata_out);
    endtask : rd
    // Counts low cycles of the reset output; a pulse that never ends stops the run
    task automatic pulse(input int lim, output int n);
        n = 0;
        for (int i = 0; i < lim && (n == 0 || reset_out_n_out !== 1'b1); i++)
        begin
            @(posedge clk_in);
            #1 if (reset_out_n_out !== 1'b1) n++;
        end
        if (reset_out_n_out !== 1'b1)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : pulse
    initial
    begin
        v = 8'($urandom(96));
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        for (int a = 0; a < 7; a++)
            rd(8'(a), a == 5 ? 8'h09 : 8'h00, "reset value");
        v = 8'($urandom);
        wr(`RSW_OFF_SOFT_RESET_REGISTER, v);
        #1 chk("soft reset", v, soft_reset_out);
        rd(`RSW_OFF_SOFT_RESET_REGISTER, v, "soft reset reg");
        wr(`RSW_OFF_PRIMARY_MODE_REGISTER, 8'h01);
        repeat (2) @(posedge clk_in);
        #1 chk("pin enable", 8'h00, 8'(reset_out_oe_out));
        for (int k = 0; k < 3; k++)
        begin
            v = {6'($urandom), (k == 0 ? 2'h0 : 2'h2)};
            wr(`RSW_OFF_MASK, k == 2 ? 8'h02 : 8'h00);
            wr(`RSW_OFF_PRIMARY_MODE_REGISTER, v);
            @(posedge clk_in) kick <= 1'b1;
            @(posedge clk_in) kick <= 1'b0;
            pulse(40, lo);
            chk("cic pulse", 8'(k != 0), 8'(lo >= 8 && lo <= 16));
            rd(`RSW_OFF_PRIMARY_MODE_REGISTER, k == 0 ? v : 8'h00, "mode reg");
            if (k != 0)
                chk("irq", 8'(k == 1), 8'(irq_out));
            wr(`RSW_OFF_INTERRUPT_STATUS_REGISTER, 8'h03);
        end
        wr(`RSW_OFF_MASK, 8'h00);
        wr(`RSW_OFF_PRIMARY_MODE_REGISTER, 8'h03);
        wr(`RSW_OFF_PRIMARY_MODE_REGISTER, 8'h00);
        rd(`RSW_OFF_STAT, 8'h0B, "wdog on");
        repeat (6)
        begin
            repeat (30) @(posedge clk_in);
            wr(`RSW_OFF_WDOG, 8'h02);
            wr(`RSW_OFF_WDOG, 8'h01);
        end
        rd(`RSW_OFF_INTERRUPT_STATUS_REGISTER, 8'h00, "serviced");
        asleep <= 1'b1;
        pulse(200, lo);
        chk("asleep expiry", 8'h00, 8'(lo));
        asleep <= 1'b0;
        repeat (100) @(posedge clk_in);
        wr(`RSW_OFF_WDOG, 8'h02);
        wr(`RSW_OFF_SOFT_RESET_REGISTER, 8'h00);
        wr(`RSW_OFF_WDOG, 8'h01);
        pulse(120, lo);
        chk("wdog pulse", 8'h08, 8'(lo));
        rd(`RSW_OFF_INTERRUPT_STATUS_REGISTER, 8'h01, "overflow flag");
        chk("irq", 8'h01, 8'(irq_out));
        rd(`RSW_OFF_STAT, 8'h09, "wdog off");
        supply_detect_enable_n_in <= 1'b0;
        wr(`RSW_OFF_PRIMARY_MODE_REGISTER, 8'h03);
        ext_reset_n_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        #1 chk("dev reset", 8'h01, 8'(device_reset_out));
        chk("reset pin", 8'h00, 8'(reset_out_n_out));
        ext_reset_n_in <= 1'b1;
        pulse(100, lo);
        chk("release delay", 8'h01, 8'(lo >= 8 && lo <= 16));
        repeat (10) @(posedge clk_in);
        rd(`RSW_OFF_STAT, 8'h09, "after ext reset");
        power_on_undervoltage_reset_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        #1 chk("mclk in por", 8'h00, 8'(mclk_run_out));
        chk("por reset", 8'h01, 8'(device_reset_out));
        power_on_undervoltage_reset_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        #1 chk("mclk in delay", 8'h01, 8'({mclk_run_out, reset_out_n_out} == 2'b10));
        supply_detect_enable_n_in <= 1'b1;
        pulse(40, lo);
        power_on_undervoltage_reset_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        #1 chk("por gated", 8'h00, 8'(device_reset_out));
        tally_and_finish();
    end
endmodule : rsw_reset_unit_tb
bind rsw_reset_unit rsw_reset_unit_sva #(.CIC_CYCLES(CIC_CYCLES)) rsw_reset_unit_sva_inst (
    .clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .ext_reset_n_in, .power_on_undervoltage_reset_in,
    .supply_detect_enable_n_in, .reset_out_n_out, .device_reset_out, .soft_reset_out, .mclk_run_out,
    .clocks_run_out, .lines_idle_out);
